/* File: logic/usc_pkg.sv */
`default_nettype none
package usc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_BAUD = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;

  // Control register field positions
  localparam int CTRL_MODE = 7;
  localparam int CTRL_ONE = 6;
  localparam int CTRL_MCE = 5;
  localparam int CTRL_REN = 4;
  localparam int CTRL_TB8 = 3;
  localparam int CTRL_RB8 = 2;
  localparam int CTRL_TI = 1;
  localparam int CTRL_RI = 0;

  // Status and mask field positions
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;

  // Values after reset
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Baud timing, 16 ticks per bit
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_HZ = 9600;
  localparam int OVS = 16;
  localparam logic [3:0] CNT_MID = 4'h7;
  localparam logic [3:0] CNT_END = 4'hf;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [15:0] DIV_RST = 16'(CLK_HZ / (BAUD_HZ * OVS) - 1);

  // Control bits as held
  typedef struct packed {
    logic mode;
    logic mce;
    logic ren;
    logic tb8;
    logic rb8;
    logic ti;
    logic ri;
  } usc_ctrl_t;

  // One-hot serial states
  typedef enum logic [4:0] {
    SER_IDLE = 5'b00001,
    SER_START = 5'b00010,
    SER_DATA = 5'b00100,
    SER_NINE = 5'b01000,
    SER_STOP = 5'b10000
  } usc_ser_t;

  // Whole state of the port
  typedef struct packed {
    usc_ctrl_t ctrl;
    logic [1:0] mask;
    logic [15:0] div;
    usc_ser_t tx_st;
    logic [7:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [2:0] tx_bit;
    logic txd;
    usc_ser_t rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [2:0] rx_bit;
    logic rx_nine;
    logic [7:0] rx_data;
    logic rxd_q;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } usc_state_t;
endpackage
`default_nettype wire

/* File: logic/usc_baud.sv */
`timescale 1ns/1ps
`default_nettype none
module usc_baud (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, low
  input wire logic ce, // Clock enable
  input wire logic [15:0] div, // Cycles per tick minus one
  output logic tick // One-cycle oversample tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } usc_baud_st_t;

  usc_baud_st_t st_reg;
  usc_baud_st_t st_next;

  // Count up to one tick per div+1 cycles
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt >= div) begin
      st_next.cnt = 16'h0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule
`default_nettype wire

/* File: logic/usc_uart.sv */
`timescale 1ns/1ps
`default_nettype none
module usc_uart (
  input wire logic pclk, // Core clock, 25 MHz
  input wire logic presetn, // Async reset, low
  input wire logic ce, // Clock enable, freezes all
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  input wire logic rxd, // Serial receive line
  output logic txd, // Serial transmit line
  output logic irq // Interrupt, high level
);
  usc_pkg::usc_state_t s_reg;
  usc_pkg::usc_state_t s_next;
  logic tick;
  logic wr_en;
  logic stop_ok;
  logic rx_take;
  logic tx_set;
  logic rx_set;

  // Oversample ticks from the divisor register
  usc_baud u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .div(s_reg.div),
    .tick(tick)
  );

  // End of one bit period
  function automatic logic bit_end(input logic tk, input logic [3:0] cnt);
    bit_end = tk && (cnt == usc_pkg::CNT_END);
  endfunction

  // Known register address
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == usc_pkg::OFS_CTRL) || (a == usc_pkg::OFS_DATA) ||
             (a == usc_pkg::OFS_BAUD) || (a == usc_pkg::OFS_STAT) ||
             (a == usc_pkg::OFS_MASK);
  endfunction

  // Read view of the control register, bit 6 fixed high
  function automatic logic [7:0] ctrl_view(input usc_pkg::usc_ctrl_t c);
    ctrl_view = {c.mode, 1'b1, c.mce, c.ren, c.tb8, c.rb8, c.ti, c.ri};
  endfunction

  assign wr_en = psel && penable && pwrite && s_reg.pready;

  // Next state of the whole port
  always_comb begin
    s_next = s_reg;
    tx_set = 1'b0;
    rx_set = 1'b0;
    stop_ok = 1'b0;
    rx_take = 1'b0;
    s_next.rxd_q = rxd;

    // Transmitter
    if (tick && (s_reg.tx_st != usc_pkg::SER_IDLE)) begin
      s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
    end
    if (bit_end(tick, s_reg.tx_cnt)) begin
      unique case (s_reg.tx_st)
        usc_pkg::SER_START: begin
          s_next.tx_st = usc_pkg::SER_DATA;
          s_next.txd = s_reg.tx_sh[0];
          s_next.tx_bit = 3'h0;
        end
        usc_pkg::SER_DATA: begin
          s_next.tx_sh = {1'b0, s_reg.tx_sh[7:1]};
          s_next.tx_bit = s_reg.tx_bit + 3'h1;
          s_next.txd = s_reg.tx_sh[1];
          if (s_reg.tx_bit == usc_pkg::BIT_LAST) begin
            if (s_reg.ctrl.mode) begin
              s_next.tx_st = usc_pkg::SER_NINE;
              s_next.txd = s_reg.ctrl.tb8;
            end else begin
              s_next.tx_st = usc_pkg::SER_STOP;
              s_next.txd = 1'b1;
              tx_set = 1'b1;
            end
          end
        end
        usc_pkg::SER_NINE: begin
          s_next.tx_st = usc_pkg::SER_STOP;
          s_next.txd = 1'b1;
          tx_set = 1'b1;
        end
        usc_pkg::SER_STOP: begin
          s_next.tx_st = usc_pkg::SER_IDLE;
        end
        usc_pkg::SER_IDLE: begin
        end
      endcase
    end

    // Receiver
    if (tick && (s_reg.rx_st != usc_pkg::SER_IDLE)) begin
      s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
    end
    unique case (s_reg.rx_st)
      usc_pkg::SER_IDLE: begin
        if (s_reg.ctrl.ren && s_reg.rxd_q && !rxd) begin
          s_next.rx_st = usc_pkg::SER_START;
          s_next.rx_cnt = 4'h0;
        end
      end
      usc_pkg::SER_START: begin
        if (tick && (s_reg.rx_cnt == usc_pkg::CNT_MID)) begin
          s_next.rx_cnt = 4'h0;
          s_next.rx_bit = 3'h0;
          s_next.rx_st = rxd ? usc_pkg::SER_IDLE : usc_pkg::SER_DATA;
        end
      end
      usc_pkg::SER_DATA: begin
        if (bit_end(tick, s_reg.rx_cnt)) begin
          s_next.rx_sh = {rxd, s_reg.rx_sh[7:1]};
          s_next.rx_bit = s_reg.rx_bit + 3'h1;
          if (s_reg.rx_bit == usc_pkg::BIT_LAST) begin
            s_next.rx_st = s_reg.ctrl.mode ? usc_pkg::SER_NINE
                                           : usc_pkg::SER_STOP;
          end
        end
      end
      usc_pkg::SER_NINE: begin
        if (bit_end(tick, s_reg.rx_cnt)) begin
          s_next.rx_nine = rxd;
          s_next.rx_st = usc_pkg::SER_STOP;
        end
      end
      usc_pkg::SER_STOP: begin
        if (bit_end(tick, s_reg.rx_cnt)) begin
          rx_take = 1'b1;
          s_next.rx_st = usc_pkg::SER_IDLE;
        end
      end
      default: begin
        s_next.rx_st = usc_pkg::SER_IDLE;
      end
    endcase
    if (!s_reg.ctrl.ren) begin
      s_next.rx_st = usc_pkg::SER_IDLE;
    end

    // Qualify a finished frame
    if (s_reg.ctrl.mode) begin
      stop_ok = !s_reg.ctrl.mce || s_reg.rx_nine;
    end else begin
      stop_ok = !s_reg.ctrl.mce || rxd;
    end
    if (rx_take && s_reg.ctrl.ren) begin
      s_next.ctrl.rb8 = s_reg.ctrl.mode ? s_reg.rx_nine : rxd;
      if (stop_ok) begin
        rx_set = 1'b1;
        s_next.rx_data = s_reg.rx_sh;
      end
    end

    // APB access phase answers one cycle after setup
    s_next.pready = psel && !penable;
    if (psel && !penable) begin
      s_next.pslverr = !mapped(paddr);
      s_next.prdata = 32'h0000_0000;
      if (paddr == usc_pkg::OFS_CTRL) begin
        s_next.prdata = {24'h000000, ctrl_view(s_reg.ctrl)};
      end else if (paddr == usc_pkg::OFS_DATA) begin
        s_next.prdata = {24'h000000, s_reg.rx_data};
      end else if (paddr == usc_pkg::OFS_BAUD) begin
        s_next.prdata = {16'h0000, s_reg.div};
      end else if (paddr == usc_pkg::OFS_STAT) begin
        s_next.prdata = {30'h0, s_reg.ctrl.ti, s_reg.ctrl.ri};
      end else if (paddr == usc_pkg::OFS_MASK) begin
        s_next.prdata = {30'h0, s_reg.mask};
      end
    end else begin
      s_next.pslverr = 1'b0;
    end

    // Register writes; flags clear by 0 in control or 1 in status
    if (wr_en) begin
      if (paddr == usc_pkg::OFS_CTRL) begin
        s_next.ctrl.mode = pwdata[usc_pkg::CTRL_MODE];
        s_next.ctrl.mce = pwdata[usc_pkg::CTRL_MCE];
        s_next.ctrl.ren = pwdata[usc_pkg::CTRL_REN];
        s_next.ctrl.tb8 = pwdata[usc_pkg::CTRL_TB8];
        s_next.ctrl.rb8 = pwdata[usc_pkg::CTRL_RB8];
        s_next.ctrl.ti = s_reg.ctrl.ti & pwdata[usc_pkg::CTRL_TI];
        s_next.ctrl.ri = s_reg.ctrl.ri & pwdata[usc_pkg::CTRL_RI];
      end else if (paddr == usc_pkg::OFS_STAT) begin
        s_next.ctrl.ti = s_reg.ctrl.ti & !pwdata[usc_pkg::EV_TX];
        s_next.ctrl.ri = s_reg.ctrl.ri & !pwdata[usc_pkg::EV_RX];
      end else if (paddr == usc_pkg::OFS_MASK) begin
        s_next.mask = pwdata[1:0];
      end else if (paddr == usc_pkg::OFS_BAUD) begin
        s_next.div = pwdata[15:0];
      end else if (paddr == usc_pkg::OFS_DATA &&
                   s_reg.tx_st == usc_pkg::SER_IDLE) begin
        s_next.tx_st = usc_pkg::SER_START;
        s_next.tx_sh = pwdata[7:0];
        s_next.tx_cnt = 4'h0;
        s_next.txd = 1'b0;
      end
    end

    // Hardware sets win over software clears
    if (tx_set) begin
      s_next.ctrl.ti = 1'b1;
    end
    if (rx_set) begin
      s_next.ctrl.ri = 1'b1;
    end

    // Interrupt level from unmasked flags
    s_next.irq = (s_next.ctrl.ti && s_next.mask[usc_pkg::EV_TX]) ||
                 (s_next.ctrl.ri && s_next.mask[usc_pkg::EV_RX]);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.ctrl <= usc_pkg::CTRL_RST;
      s_reg.mask <= usc_pkg::MASK_RST;
      s_reg.div <= usc_pkg::DIV_RST;
      s_reg.tx_st <= usc_pkg::SER_IDLE;
      s_reg.rx_st <= usc_pkg::SER_IDLE;
      s_reg.txd <= 1'b1;
      s_reg.rxd_q <= 1'b1;
      s_reg.rx_data <= usc_pkg::DATA_RST;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flops
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign txd = s_reg.txd;
  assign irq = s_reg.irq;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Register bus answers
  chk_bit6_reads_one: assert property (
    pready && paddr == usc_pkg::OFS_CTRL |-> prdata[usc_pkg::CTRL_ONE])
    else $error("control bit 6 read as zero");

  chk_slverr_map: assert property (
    pready |-> pslverr == !mapped(paddr))
    else $error("slave error does not match address");

  chk_pready_pulse: assert property (
    ce && pready |=> !pready)
    else $error("ready held longer than one cycle");

  // Receiver gating and qualification
  chk_ren_blocks_rx: assert property (
    ce && !s_reg.ctrl.ren |=> s_reg.rx_st == usc_pkg::SER_IDLE)
    else $error("receiver left idle while disabled");

  chk_mce8_stop: assert property (
    ce && rx_take && !s_reg.ctrl.mode && s_reg.ctrl.mce && !rxd
    && !s_reg.ctrl.ri && !wr_en |=> !s_reg.ctrl.ri)
    else $error("rx done set on low stop bit");

  chk_mce9_nine: assert property (
    ce && rx_take && s_reg.ctrl.mode && s_reg.ctrl.mce && !s_reg.rx_nine
    && !s_reg.ctrl.ri && !wr_en |=> !s_reg.ctrl.ri)
    else $error("rx done set on low ninth bit");

  chk_rb8_load: assert property (
    ce && rx_take && s_reg.ctrl.ren && !wr_en
    |=> s_reg.ctrl.rb8 == ($past(s_reg.ctrl.mode) ? $past(s_reg.rx_nine)
                                                  : $past(rxd)))
    else $error("rx ninth bit not loaded");

  chk_rx_data_hold: assert property (
    ce && rx_take && !stop_ok |=> $stable(s_reg.rx_data))
    else $error("rx data taken from rejected frame");

  // Transmit ninth bit and done flag
  chk_tx_nine_bit: assert property (
    $rose(s_reg.tx_st == usc_pkg::SER_NINE) |-> txd == $past(s_reg.ctrl.tb8))
    else $error("ninth bit differs from tb8");

  chk_ti_at_stop: assert property (
    $rose(s_reg.tx_st == usc_pkg::SER_STOP) |-> s_reg.ctrl.ti && txd)
    else $error("tx done missing at stop start");

  chk_ti_only_stop: assert property (
    $rose(s_reg.ctrl.ti) |-> s_reg.tx_st == usc_pkg::SER_STOP
    && $past(s_reg.tx_st) != usc_pkg::SER_STOP)
    else $error("tx done set outside stop start");

  // Sticky flags and interrupt level
  chk_ti_sticky: assert property (
    s_reg.ctrl.ti && !(ce && wr_en) |=> s_reg.ctrl.ti)
    else $error("tx done cleared without software");

  chk_ri_sticky: assert property (
    s_reg.ctrl.ri && !(ce && wr_en) |=> s_reg.ctrl.ri)
    else $error("rx done cleared without software");

  chk_ri_sets: assert property (
    ce && s_reg.ctrl.ren && s_reg.rx_st == usc_pkg::SER_STOP
    && bit_end(tick, s_reg.rx_cnt)
    && (!s_reg.ctrl.mce || (s_reg.ctrl.mode ? s_reg.rx_nine : rxd))
    |=> s_reg.ctrl.ri)
    else $error("rx done not set at stop sample");

  chk_irq_level: assert property (
    ce ##1 1'b1 |-> irq == ((s_reg.ctrl.ti && s_reg.mask[usc_pkg::EV_TX]) ||
                            (s_reg.ctrl.ri && s_reg.mask[usc_pkg::EV_RX])))
    else $error("irq level wrong");

  // Main scenarios reached
  cov_tx_frame9: cover property (
    s_reg.tx_st == usc_pkg::SER_NINE ##[1:400] s_reg.ctrl.ti);
  cov_rx_done: cover property (ce && rx_set);
  cov_rx_rejected: cover property (ce && rx_take && !stop_ok);
  cov_irq: cover property ($rose(irq));
  cov_tx_frame8: cover property (
    $rose(s_reg.tx_st == usc_pkg::SER_STOP) && !s_reg.ctrl.mode);
endmodule
`default_nettype wire

/* File: sim/usc_remote.sv */
`timescale 1ns/1ps
`default_nettype none
module usc_remote #(
  parameter int BIT_CYC = 16
) (
  input wire logic pclk, // Core clock
  input wire logic txd, // Line from the port
  output logic rxd // Line into the port
);
  logic [8:0] got; // Last captured bits after start
  int frames; // Frames captured so far
  // Idle line is high
  initial begin
    rxd = 1'b1;
    got = '0;
    frames = 0;
  end
  // Start, eight bits LSB first, optional ninth, stop
  task automatic send(input logic [7:0] d, input logic nine_on,
                      input logic b9, input logic stop);
    logic [10:0] fr;
    int n;
    fr = nine_on ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
    n = nine_on ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      rxd <= fr[i];
      repeat (BIT_CYC - 1) @(posedge pclk);
    end
    @(posedge pclk);
    rxd <= 1'b1;
    repeat (2 * BIT_CYC) @(posedge pclk);
  endtask
  // Samples nine bits mid-bit after each start edge
  always begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYC) @(posedge pclk);
      got[i] = txd;
    end
    frames++;
    wait (txd === 1'b1);
  end
endmodule
`default_nettype wire

/* File: sim/tb_uart_serial_control_status.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_uart_serial_control_status;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  logic ce;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  usc_uart u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .txd(txd), .irq(irq));
  usc_remote u_rem (.pclk(pclk), .txd(txd), .rxd(rxd));
  // Clock, 40 ns period
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Verdict and end of run
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      close_out();
    end
  end
  // Compare and report
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, answer taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check("apb_ready", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait on the interrupt line
  task automatic wait_irq();
    int n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    check("irq_wait", {31'h0, irq}, 32'h1);
  endtask
  // Expected rx done for enable, check bit and qualifying level
  function automatic logic exp_rx_done(input logic en, input logic chk,
                                       input logic lvl);
    exp_rx_done = en && (!chk || lvl);
  endfunction
  // Expected captured bits: data, then ninth bit or stop bit
  function automatic logic [8:0] exp_tx_bits(input logic nine,
                                             input logic b9,
                                             input logic [7:0] dat);
    exp_tx_bits = {nine ? b9 : 1'b1, dat};
  endfunction
  // Main sequence
  initial begin
    logic [7:0] d, exp_dat;
    logic m, tb8, mce, ren, s, exp_ri, exp_rb8;
    logic [8:0] exp_bits;
    int f, n;
    void'($urandom(54523));
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    ce = 1'b1;
    exp_rb8 = 1'b0;
    exp_dat = 8'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, fixed bit, unmapped place
    apb(1'b0, usc_pkg::OFS_CTRL, 32'h0);
    check("ctrl_rst", rd, 32'h40);
    apb(1'b1, usc_pkg::OFS_CTRL, 32'hbf);
    apb(1'b0, usc_pkg::OFS_CTRL, 32'h0);
    check("ctrl_wr", rd & 32'hfb, 32'hf8);
    apb(1'b1, usc_pkg::OFS_CTRL, 32'h0);
    apb(1'b0, usc_pkg::OFS_CTRL, 32'h0);
    check("ctrl_zero", rd & 32'hfb, 32'h40);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped_err", {31'h0, err}, 32'h1);
    check("unmapped_data", rd, 32'h0);
    apb(1'b0, usc_pkg::OFS_MASK, 32'h0);
    check("mask_rst", rd, 32'h0);
    apb(1'b1, usc_pkg::OFS_BAUD, 32'h0);
    apb(1'b1, usc_pkg::OFS_MASK, 32'h3);
    // Transmit in both modes, edge data values
    for (int i = 0; i < 4; i++) begin
      m = i[0];
      tb8 = 1'($urandom);
      d = (i == 3) ? 8'hff : ((i == 0) ? 8'h00 : 8'($urandom));
      apb(1'b1, usc_pkg::OFS_CTRL, {24'h0, m, 3'h0, tb8, 3'h0});
      f = u_rem.frames;
      apb(1'b1, usc_pkg::OFS_DATA, {24'h0, d});
      wait_irq();
      check("txd_at_done", {31'h0, txd}, 32'h1);
      n = 0;
      while (u_rem.frames == f && n < 400) begin
        @(posedge pclk);
        n++;
      end
      check("tx_frames", u_rem.frames, f + 1);
      exp_bits = exp_tx_bits(m, tb8, d);
      check("tx_frame", {23'h0, u_rem.got}, {23'h0, exp_bits});
      apb(1'b0, usc_pkg::OFS_CTRL, 32'h0);
      check("tx_done", {31'h0, rd[1]}, 32'h1);
      apb(1'b1, usc_pkg::OFS_MASK, 32'h1);
      repeat (2) @(posedge pclk);
      check("irq_masked", {31'h0, irq}, 32'h0);
      apb(1'b1, usc_pkg::OFS_MASK, 32'h3);
      repeat (2) @(posedge pclk);
      check("irq_tx", {31'h0, irq}, 32'h1);
      if (i[1]) begin
        apb(1'b1, usc_pkg::OFS_STAT, 32'h2);
      end else begin
        apb(1'b1, usc_pkg::OFS_CTRL, {24'h0, m, 3'h0, tb8, 3'h0});
      end
      repeat (2) @(posedge pclk);
      check("irq_clr", {31'h0, irq}, 32'h0);
    end
    // Receive over every mode, check, enable and bit level
    for (int i = 0; i < 16; i++) begin
      m = i[0];
      mce = i[1];
      ren = i[2];
      s = i[3];
      d = 8'($urandom);
      apb(1'b1, usc_pkg::OFS_CTRL, {24'h0, m, 1'b0, mce, ren, 4'h0});
      exp_ri = exp_rx_done(ren, mce, s);
      exp_rb8 = ren && s;
      if (exp_ri) exp_dat = d;
      u_rem.send(d, m, s, m ? 1'b1 : s);
      apb(1'b0, usc_pkg::OFS_CTRL, 32'h0);
      check("rx_done", {31'h0, rd[0]}, {31'h0, exp_ri});
      check("rx_ninth", {31'h0, rd[2]}, {31'h0, exp_rb8});
      check("irq_rx", {31'h0, irq}, {31'h0, exp_ri});
      apb(1'b0, usc_pkg::OFS_DATA, 32'h0);
      check("rx_data", rd, {24'h0, exp_dat});
      if (exp_ri) begin
        apb(1'b1, usc_pkg::OFS_CTRL, {24'h0, m, 1'b0, mce, ren, 4'h1});
        apb(1'b0, usc_pkg::OFS_CTRL, 32'h0);
        check("rx_keep", {31'h0, rd[0]}, 32'h1);
      end
    end
    // Clock enable low freezes a frame in its start bit
    apb(1'b1, usc_pkg::OFS_DATA, 32'h55);
    ce <= 1'b0;
    repeat (40) @(posedge pclk);
    check("ce_freeze", {31'h0, txd}, 32'h0);
    ce <= 1'b1;
    // Reset in mid-run brings back the reset values
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    check("irq_rst", {31'h0, irq}, 32'h0);
    apb(1'b0, usc_pkg::OFS_CTRL, 32'h0);
    check("ctrl_rst2", rd, 32'h40);
    apb(1'b0, usc_pkg::OFS_BAUD, 32'h0);
    check("baud_rst", rd, {16'h0, usc_pkg::DIV_RST});
    apb(1'b0, usc_pkg::OFS_DATA, 32'h0);
    check("data_rst", rd, {24'h0, usc_pkg::DATA_RST});
    close_out();
  end
endmodule
`default_nettype wire
